// *** rtl/tile_control_status_regs.v ***
// Processor status registers: tile control, boot status, security and ring oscillators.
`timescale 1ns/100ps
`include "tile_status_map.vh"
module tile_control_status_regs (
  input wire mclk, // tile core clock, 125 MHz
  input wire rst_b, // asynchronous reset, active low
  input wire ps_wr, // status write strobe, one cycle
  input wire ps_rd, // status read strobe, one cycle
  input wire [7:0] ps_num, // status register number
  input wire [31:0] ps_wdata, // write data
  output reg [31:0] ps_rdata, // read data, valid the cycle after ps_rd
  output reg ps_rvalid, // read data valid pulse
  output reg ps_err, // pulse: write refused or unmapped number
  input wire [7:0] proc_num, // processor number
  input wire boot_from_ram, // boot ROM boots from RAM
  input wire boot_from_jtag, // boot ROM boots from JTAG
  input wire core1_off, // second core powered off
  input wire otp_no_poll, // skip OTP read level polling
  input wire overwrite_boot_mode, // boot mode overwritten
  input wire [1:0] boot_pll_pins, // boot PLL mode pins
  input wire otp_sec_valid, // pulse: OTP security word available
  input wire [31:0] otp_sec_word, // security word from OTP
  input wire all_threads_paused, // every active thread is paused
  input wire [3:0] osc_clk, // four ring oscillator clocks
  output wire [7:0] rgmii_tx_delay, // transmit data delay in PLL cycles
  output wire rgmii_tx_clk, // divided transmit clock
  output wire rgmii_ports_en, // reduced gigabit ports enabled
  output wire lp_clk_en, // low-power divider clock enable pulse train
  output wire lp_div_active, // low-power divider currently dividing
  output wire utmi_mode, // 1 UTMI, 0 ULPI
  output wire ulpi_hw_en, // ULPI support module enabled
  output wire global_debug_dis, // global debug disabled
  output wire jtag_tap_dis, // JTAG debug TAP disabled
  output wire [3:0] otp_sector_lock, // per-sector OTP lock, all-lock folded in
  output wire otp_redundancy_en, // OTP redundancy enabled
  output wire boot_from_otp, // boot image read from OTP
  output wire jtag_cfg_block, // JTAG blocked from PLL/boot config
  output wire [3:0] ring_osc_run // oscillator enables
);
  // ****************************************************************
  // Reset release
  // ****************************************************************
  reg rst_s1;
  reg rst_int_b;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_int_b <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_int_b <= rst_s1;
    end
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg [31:0] tile_ctrl_reg;
  reg [31:0] sec_cfg_reg;
  reg [1:0] ring_ctrl_reg;
  reg [31:0] boot_stat_reg;
  wire wr_ctrl = ps_wr && (ps_num == `REG_TILE_CTRL);
  wire wr_sec = ps_wr && (ps_num == `REG_SEC_CFG);
  wire wr_ring = ps_wr && (ps_num == `REG_RING_CTRL);
  wire sec_locked = sec_cfg_reg[`SEC_LOCK_BIT];

  always @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      tile_ctrl_reg <= `TILE_CTRL_RESET;
      ring_ctrl_reg <= 2'b00;
    end else begin
      if (wr_ctrl) begin
        tile_ctrl_reg <= ps_wdata & `TILE_CTRL_WMASK;
      end
      if (wr_ring) begin
        ring_ctrl_reg <= ps_wdata[1:0];
      end
    end
  end

  // Security word comes from OTP; software writes only while unlocked.
  always @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      sec_cfg_reg <= 32'h00000000;
    end else if (otp_sec_valid) begin
      sec_cfg_reg <= otp_sec_word & `SEC_WMASK;
    end else if (wr_sec && !sec_locked) begin
      sec_cfg_reg <= ps_wdata & `SEC_WMASK;
    end
  end

  // Boot status is sampled every cycle; the register is never written.
  always @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      boot_stat_reg <= 32'h00000000;
    end else begin
      boot_stat_reg <= {8'h00, proc_num, 7'h00, overwrite_boot_mode, 2'b00,
        core1_off, otp_no_poll, boot_from_ram, boot_from_jtag,
        boot_pll_pins};
    end
  end

  // ****************************************************************
  // Ring oscillators
  // ****************************************************************
  wire [15:0] osc_count [0:3];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_osc
      ring_osc_counter u_osc (
        .osc_clk(osc_clk[gi]),
        .run(ring_osc_run[gi]),
        .count(osc_count[gi])
      );
    end
  endgenerate
  // Counters 0,1 are core cell/wire; 2,3 peripheral cell/wire.
  assign ring_osc_run = {{2{ring_ctrl_reg[`RING_PERI_BIT]}},
    {2{ring_ctrl_reg[`RING_CORE_BIT]}}};

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Counter reads are unsynchronised; software waits ten cycles after stopping.
  always @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      ps_rdata <= 32'h00000000;
      ps_rvalid <= 1'b0;
      ps_err <= 1'b0;
    end else begin
      ps_rvalid <= ps_rd;
      ps_err <= (wr_sec && sec_locked) || (ps_wr && (ps_num == `REG_BOOT_STAT)) ||
        ((ps_rd || ps_wr) && !(ps_num == `REG_TILE_CTRL || ps_num == `REG_BOOT_STAT ||
        ps_num == `REG_SEC_CFG || ps_num == `REG_RING_CTRL ||
        (!ps_wr && ps_num >= `REG_RING_VAL0 && ps_num <= `REG_RING_VAL3)));
      if (ps_rd) begin
        case (ps_num)
          `REG_TILE_CTRL: ps_rdata <= tile_ctrl_reg;
          `REG_BOOT_STAT: ps_rdata <= boot_stat_reg;
          `REG_SEC_CFG: ps_rdata <= sec_cfg_reg;
          `REG_RING_CTRL: ps_rdata <= {30'h00000000, ring_ctrl_reg};
          8'h07: ps_rdata <= {16'h0000, osc_count[0]};
          8'h08: ps_rdata <= {16'h0000, osc_count[1]};
          8'h09: ps_rdata <= {16'h0000, osc_count[2]};
          8'h0a: ps_rdata <= {16'h0000, osc_count[3]};
          default: ps_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Tile control outputs
  // ****************************************************************
  assign rgmii_tx_delay = tile_ctrl_reg[`TXDLY_HI:`TXDLY_LO];
  assign rgmii_ports_en = tile_ctrl_reg[`RGMII_EN_BIT];
  assign utmi_mode = tile_ctrl_reg[`UTMI_SEL_BIT];
  assign ulpi_hw_en = tile_ctrl_reg[`ULPI_EN_BIT];

  rgmii_tx_clk_div u_txdiv (
    .mclk(mclk),
    .rst_int_b(rst_int_b),
    .enable(rgmii_ports_en),
    .div_value(tile_ctrl_reg[`TXDIV_HI:`TXDIV_LO]),
    .tx_clk(rgmii_tx_clk)
  );

  // Low-power divider: one enable pulse every LP_DIV_RATIO cycles while active.
  reg [7:0] lp_cnt_reg;
  assign lp_div_active = tile_ctrl_reg[`DIV_EN_BIT] &&
    (!tile_ctrl_reg[`DYN_MODE_BIT] || all_threads_paused);
  always @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      lp_cnt_reg <= 8'h00;
    end else if (!lp_div_active || lp_cnt_reg == `LP_DIV_RATIO - 8'h01) begin
      lp_cnt_reg <= 8'h00;
    end else begin
      lp_cnt_reg <= lp_cnt_reg + 8'h01;
    end
  end
  assign lp_clk_en = !lp_div_active || (lp_cnt_reg == 8'h00);

  // ****************************************************************
  // Security outputs
  // ****************************************************************
  assign global_debug_dis = sec_cfg_reg[`SEC_GDBG_BIT];
  assign jtag_tap_dis = sec_cfg_reg[`SEC_TAP_BIT];
  assign otp_sector_lock = sec_cfg_reg[`SEC_SECT_HI:`SEC_SECT_LO] |
    {4{sec_cfg_reg[`SEC_OTP_ALL_BIT]}};
  assign otp_redundancy_en = sec_cfg_reg[`SEC_REDUND_BIT];
  assign boot_from_otp = sec_cfg_reg[`SEC_OTPBOOT_BIT];
  assign jtag_cfg_block = sec_cfg_reg[`SEC_JTAGCFG_BIT];
endmodule // tile_control_status_regs

// *** rtl/tile_status_map.vh ***
// Register numbers, field positions, reset values and timing counts for the tile status registers.
// Function
// - Tile control bits 25:18 hold transmit data delay in PLL cycles, reset zero.
// - Divider counter raises transmit clock at field value, lowers it at value halved.
// - Tile control bit 8 enables the reduced gigabit interface ports, reset zero.
// - Bit 5 set makes low-power divider act only while all active threads pause.
// - Tile control bit 4 enables the low-power PLL clock divider, reset zero.
// - Bit 2 selects UTMI when one, ULPI when zero; bit 1 enables ULPI support.
// - Boot status is read-only with processor number in bits 23:16.
// - Boot status bit 3 reports boot from RAM, bit 2 boot from JTAG.
// - Boot status bit 5 reports the second core powered off.
// - Boot status bit 4 reports the skip-OTP-read-level-poll flag.
// - Boot status bits 1:0 return the sampled boot PLL mode pins.
// - Security configuration bit 31 set refuses further writes to that register.
// - Security bit 14 disables global debug; bit 0 disables JTAG debug TAP.
// - Security bit 12 locks all OTP sectors; bits 11:8 lock one sector each.
// - Security bit 7 enables OTP redundancy.
// - Security bit 5 forces the boot image to be read from OTP.
// - Security bit 4 blocks JTAG access to PLL and boot configuration.
// - Security configuration is loaded from the OTP security word.
// - Four oscillators clock counters; control bit 1 core pair, bit 0 peripheral pair.
// - Oscillators run asynchronously to the tile clock, usable as random bits.
`ifndef TILE_STATUS_MAP_VH
`define TILE_STATUS_MAP_VH
`define REG_TILE_CTRL 8'h02
`define REG_BOOT_STAT 8'h03
`define REG_SEC_CFG 8'h05
`define REG_RING_CTRL 8'h06
`define REG_RING_VAL0 8'h07
`define REG_RING_VAL3 8'h0a
`define TILE_CTRL_WMASK 32'h03ffff36
`define TILE_CTRL_RESET 32'h00000000
`define TXDLY_HI 25
`define TXDLY_LO 18
`define TXDIV_HI 17
`define TXDIV_LO 9
`define RGMII_EN_BIT 8
`define DYN_MODE_BIT 5
`define DIV_EN_BIT 4
`define UTMI_SEL_BIT 2
`define ULPI_EN_BIT 1
`define SEC_WMASK 32'h80005fb1
`define SEC_LOCK_BIT 31
`define SEC_GDBG_BIT 14
`define SEC_OTP_ALL_BIT 12
`define SEC_SECT_HI 11
`define SEC_SECT_LO 8
`define SEC_REDUND_BIT 7
`define SEC_OTPBOOT_BIT 5
`define SEC_JTAGCFG_BIT 4
`define SEC_TAP_BIT 0
`define RING_CORE_BIT 1
`define RING_PERI_BIT 0
`define RING_STOP_CYCLES 10
`define LP_DIV_RATIO 8'h08
`endif

// *** rtl/ring_osc_counter.v ***
// Run-gated ring oscillator model with its own 16-bit counter.
`timescale 1ns/100ps
module ring_osc_counter (
  input wire osc_clk, // oscillator clock, asynchronous to mclk
  input wire run, // oscillator enable level from the tile clock domain
  output reg [15:0] count // counter value, not reset
);
  reg run_meta;
  reg run_sync;
  reg run_seen;
  // The counter has no reset, so its value survives system reset.
  // Each start clears it, so a counter that powers up unknown still reads as a number.
  always @(posedge osc_clk) begin
    run_meta <= run;
    run_sync <= run_meta;
    run_seen <= run_sync;
    if (run_sync && !run_seen) begin
      count <= 16'h0000;
    end else if (run_sync) begin
      count <= count + 16'h0001;
    end
  end
endmodule // ring_osc_counter

// *** rtl/rgmii_tx_clk_div.v ***
// PLL-rate divider that forms the reduced gigabit transmit clock.
`timescale 1ns/100ps
module rgmii_tx_clk_div (
  input wire mclk, // PLL output clock
  input wire rst_int_b, // synchronised reset, active low
  input wire enable, // interface ports enabled
  input wire [8:0] div_value, // ratio minus one
  output reg tx_clk // divided transmit clock
);
  reg [8:0] cnt_reg;
  always @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      cnt_reg <= 9'h000;
      tx_clk <= 1'b0;
    end else if (!enable) begin
      cnt_reg <= 9'h000;
      tx_clk <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg >= div_value) ? 9'h000 : cnt_reg + 9'h001;
      if (cnt_reg == div_value) begin
        tx_clk <= 1'b1;
      end else if (cnt_reg == (div_value >> 1)) begin
        tx_clk <= 1'b0;
      end
    end
  end
endmodule // rgmii_tx_clk_div

// *** test/tile_control_status_regs_assertions.sv ***
// Concurrent checks on the tile status register ports.
`timescale 1ns/100ps
module tile_control_status_regs_assertions (
  input wire logic mclk, // tile clock
  input wire logic rst_b, // reset, active low
  input wire logic ps_wr, // write strobe
  input wire logic ps_rd, // read strobe
  input wire logic [7:0] ps_num, // register number
  input wire logic [31:0] ps_wdata, // write data
  input wire logic ps_rvalid, // read answer
  input wire logic ps_err, // refusal pulse
  input wire logic otp_sec_valid, // OTP load pulse
  input wire logic [31:0] otp_sec_word, // OTP word
  input wire logic [7:0] rgmii_tx_delay, // transmit delay
  input wire logic rgmii_ports_en, // ports enable
  input wire logic lp_clk_en, // low-power enable train
  input wire logic lp_div_active, // divider active
  input wire logic utmi_mode, // transceiver mode
  input wire logic ulpi_hw_en, // support module enable
  input wire logic global_debug_dis, // debug disable
  input wire logic jtag_tap_dis, // TAP disable
  input wire logic [3:0] otp_sector_lock, // sector locks
  input wire logic [3:0] ring_osc_run // oscillator enables
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire tw = ps_wr && ps_num == 8'h02;
  wire sw = ps_wr && ps_num == 8'h05 && !otp_sec_valid;
  rd_answer_a: assert property (ps_rd |=> ps_rvalid) else $error("read not answered");
  rd_quiet_a: assert property (!ps_rd |=> !ps_rvalid) else $error("spurious read answer");
  boot_wr_err_a: assert property (ps_wr && ps_num == 8'h03 |=> ps_err)
    else $error("boot status write accepted");
  tx_delay_a: assert property (tw |=> rgmii_tx_delay == $past(ps_wdata[25:18]))
    else $error("transmit delay not written");
  ports_en_a: assert property (tw |=> rgmii_ports_en == $past(ps_wdata[8]))
    else $error("ports enable not written");
  usb_mode_a: assert property (tw |=> {utmi_mode, ulpi_hw_en} == $past(ps_wdata[2:1]))
    else $error("usb mode bits not written");
  lp_idle_a: assert property (!lp_div_active |-> lp_clk_en) else $error("clock gated");
  lp_pulse_a: assert property (lp_clk_en && lp_div_active ##1 lp_div_active |-> !lp_clk_en)
    else $error("divider pulses back to back");
  sec_wr_a: assert property (sw |=> ps_err || jtag_tap_dis == $past(ps_wdata[0]))
    else $error("security write lost");
  sec_hold_a: assert property (sw |=> !ps_err || $stable({global_debug_dis, jtag_tap_dis}))
    else $error("locked security changed");
  otp_load_a: assert property (otp_sec_valid |=> otp_sector_lock ==
    ($past(otp_sec_word[11:8]) | {4{$past(otp_sec_word[12])}})) else $error("bad sector lock");
  ring_run_a: assert property (ps_wr && ps_num == 8'h06 |=> ring_osc_run ==
    {{2{$past(ps_wdata[0])}}, {2{$past(ps_wdata[1])}}}) else $error("bad oscillator enables");
endmodule // tile_control_status_regs_assertions

// *** test/tb_tile_control_status_regs.sv ***
// Self-checking bench for the tile status registers.
`timescale 1ns/100ps
module tb_tile_control_status_regs;
  logic mclk = 1'b0, rst_b = 1'b0, ps_wr = 1'b0, ps_rd = 1'b0, otp_sec_valid = 1'b0;
  logic all_threads_paused = 1'b0;
  logic [7:0] ps_num = 8'h00;
  logic [31:0] ps_wdata = 32'h00000000, otp_sec_word = 32'h00000000;
  logic [14:0] bt = 15'h0000;
  logic [3:0] osc_clk = 4'h0;
  wire [31:0] ps_rdata;
  wire ps_rvalid, ps_err, rgmii_tx_clk, rgmii_ports_en, lp_clk_en, lp_div_active, utmi_mode;
  wire ulpi_hw_en, global_debug_dis, jtag_tap_dis, otp_redundancy_en, boot_from_otp, jtag_cfg_block;
  wire [7:0] rgmii_tx_delay;
  wire [3:0] otp_sector_lock, ring_osc_run;
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #4 mclk = ~mclk;
  always #3.1 osc_clk = ~osc_clk;
  tile_control_status_regs dut (.mclk(mclk), .rst_b(rst_b), .ps_wr(ps_wr), .ps_rd(ps_rd),
    .ps_num(ps_num), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid),
    .ps_err(ps_err), .proc_num(bt[14:7]), .overwrite_boot_mode(bt[6]), .core1_off(bt[5]),
    .otp_no_poll(bt[4]), .boot_from_ram(bt[3]), .boot_from_jtag(bt[2]), .boot_pll_pins(bt[1:0]),
    .otp_sec_valid(otp_sec_valid), .otp_sec_word(otp_sec_word), .osc_clk(osc_clk),
    .all_threads_paused(all_threads_paused), .rgmii_tx_delay(rgmii_tx_delay),
    .rgmii_tx_clk(rgmii_tx_clk), .rgmii_ports_en(rgmii_ports_en), .lp_clk_en(lp_clk_en),
    .lp_div_active(lp_div_active), .utmi_mode(utmi_mode), .ulpi_hw_en(ulpi_hw_en),
    .global_debug_dis(global_debug_dis), .jtag_tap_dis(jtag_tap_dis),
    .otp_sector_lock(otp_sector_lock), .otp_redundancy_en(otp_redundancy_en),
    .boot_from_otp(boot_from_otp), .jtag_cfg_block(jtag_cfg_block), .ring_osc_run(ring_osc_run));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] n, input logic [31:0] d, input logic err);
    @(posedge mclk);
    ps_wr <= 1'b1;
    ps_num <= n;
    ps_wdata <= d;
    @(posedge mclk);
    ps_wr <= 1'b0;
    @(negedge mclk);
    chk({31'h0, ps_err}, {31'h0, err}, "write refusal");
  endtask
  task automatic rd(input logic [7:0] n, input logic [31:0] exp);
    @(posedge mclk);
    ps_rd <= 1'b1;
    ps_num <= n;
    @(posedge mclk);
    ps_rd <= 1'b0;
    @(negedge mclk);
    chk({31'h0, ps_rvalid}, 32'h1, "read valid");
    chk(ps_rdata, exp, "read data");
  endtask
  // Reads a stopped counter twice: it must hold, be a number, and have counted.
  task automatic rd_osc(input logic [7:0] n);
    logic [31:0] v;
    @(posedge mclk);
    ps_rd <= 1'b1;
    ps_num <= n;
    @(posedge mclk);
    ps_rd <= 1'b0;
    @(negedge mclk);
    v = ps_rdata;
    rd(n, v);
    chk({31'h0, v != 32'h0 && v[31:16] == 16'h0}, 32'h1, "counter value");
  endtask
  task automatic ld(input logic [31:0] w);
    @(posedge mclk);
    otp_sec_valid <= 1'b1;
    otp_sec_word <= w;
    @(posedge mclk);
    otp_sec_valid <= 1'b0;
  endtask
  // Counts transmit clock rises or enable pulses over 40 cycles.
  task automatic cnt(input bit sel, input int exp);
    int k;
    logic p;
    k = 0;
    p = rgmii_tx_clk;
    repeat (40) begin
      @(negedge mclk);
      k += sel ? lp_clk_en : (rgmii_tx_clk && !p);
      p = rgmii_tx_clk;
    end
    chk(k, exp, "cycle count");
  endtask
  task automatic t_tile;
    rd(8'h02, 32'h00000000);
    wr(8'h02, 32'hffffffff, 1'b0);
    rd(8'h02, 32'h03ffff36);
    chk({rgmii_tx_delay, rgmii_ports_en, utmi_mode, ulpi_hw_en}, 32'h7ff, "tile outputs");
    wr(8'h02, 32'h00000000, 1'b0);
    chk({rgmii_tx_delay, rgmii_ports_en, utmi_mode, ulpi_hw_en}, 32'h0, "tile outputs");
    wr(8'h04, 32'h00000001, 1'b1);
    $display("tile control test done");
  endtask
  task automatic t_clocks;
    wr(8'h02, 32'h00000700, 1'b0);
    cnt(1'b0, 10);
    wr(8'h02, 32'h00000010, 1'b0);
    cnt(1'b1, 5);
    wr(8'h02, 32'h00000030, 1'b0);
    cnt(1'b1, 40);
    chk({31'h0, lp_div_active}, 32'h0, "divider active");
    @(posedge mclk);
    all_threads_paused <= 1'b1;
    cnt(1'b1, 5);
    chk({31'h0, lp_div_active}, 32'h1, "divider active");
    @(posedge mclk);
    all_threads_paused <= 1'b0;
    $display("clock divider test done");
  endtask
  task automatic t_boot;
    @(posedge mclk);
    bt <= {8'h5a, 1'b1, 6'h2a};
    repeat (2) @(posedge mclk);
    rd(8'h03, 32'h005a012a);
    @(posedge mclk);
    bt <= {8'ha5, 1'b0, 6'h15};
    repeat (2) @(posedge mclk);
    rd(8'h03, 32'h00a50015);
    wr(8'h03, 32'hffffffff, 1'b1);
    rd(8'h03, 32'h00a50015);
    $display("boot status test done");
  endtask
  task automatic t_sec;
    ld(32'h000011a0);
    rd(8'h05, 32'h000011a0);
    chk({otp_sector_lock, otp_redundancy_en, boot_from_otp, jtag_cfg_block, global_debug_dis,
      jtag_tap_dis}, 32'h1f8, "security outputs");
    wr(8'h05, 32'h80004011, 1'b0);
    chk({otp_sector_lock, otp_redundancy_en, boot_from_otp, jtag_cfg_block, global_debug_dis,
      jtag_tap_dis}, 32'h007, "security outputs");
    wr(8'h05, 32'h00000000, 1'b1);
    rd(8'h05, 32'h80004011);
    ld(32'h00000000);
    rd(8'h05, 32'h00000000);
    $display("security test done");
  endtask
  task automatic t_ring;
    rd(8'h06, 32'h00000000);
    wr(8'h06, 32'hffffffff, 1'b0);
    chk({28'h0, ring_osc_run}, 32'hf, "oscillator enables");
    repeat (20) @(posedge mclk);
    wr(8'h06, 32'h00000001, 1'b0);
    chk({28'h0, ring_osc_run}, 32'hc, "oscillator enables");
    wr(8'h06, 32'h00000000, 1'b0);
    repeat (10) @(posedge mclk);
    rd_osc(8'h07);
    rd_osc(8'h08);
    rd_osc(8'h09);
    rd_osc(8'h0a);
    wr(8'h07, 32'h00000000, 1'b1);
    $display("ring oscillator test done");
  endtask
  task automatic t_reset;
    wr(8'h02, 32'h00000100, 1'b0);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, rgmii_ports_en}, 32'h0, "ports after reset");
    rd(8'h02, 32'h00000000);
    $display("reset test done");
  endtask
  task automatic results;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      results;
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_tile;
    t_clocks;
    t_boot;
    t_sec;
    t_ring;
    t_reset;
    results;
  end
endmodule // tb_tile_control_status_regs
bind tile_control_status_regs tile_control_status_regs_assertions chk_i (.mclk(mclk),
  .rst_b(rst_b), .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_num(ps_num), .ps_wdata(ps_wdata),
  .ps_rvalid(ps_rvalid), .ps_err(ps_err), .otp_sec_valid(otp_sec_valid),
  .otp_sec_word(otp_sec_word), .rgmii_tx_delay(rgmii_tx_delay), .rgmii_ports_en(rgmii_ports_en),
  .lp_clk_en(lp_clk_en), .lp_div_active(lp_div_active), .utmi_mode(utmi_mode),
  .ulpi_hw_en(ulpi_hw_en), .global_debug_dis(global_debug_dis), .jtag_tap_dis(jtag_tap_dis),
  .otp_sector_lock(otp_sector_lock), .ring_osc_run(ring_osc_run));
